// ===== design/logger_pkg.sv
// How it works
// - Samples are recorded while the recording-run and parameters-valid flags are set and, outside cycle recording, below the limit; not otherwise.
// - Hardware never clears the recording-run flag; only software does.
// - Limit-reached flag is high at the configured count or in cycle recording.
// - Store trigger rising edge starts a card copy only when store code is 16#5AA5.
// - Store code 16#5AA5 stores, 0 means storing done, others are invalid.
// - A 32-bit read-only record count increments by one per captured record.
// - Saving starts automatically when the limit-reached flag rises, if store code is 16#5AA5 and a card is present.
// - Card-present flag follows the filtered card detect pin.
// - Storing-busy flag is high exactly while a card transfer runs.
// - Card-error flag is set when a store fails or is refused (no card, or an invalid code on a trigger edge); only a clean store finish clears it.
// - Last card error code is readable; it reads as valid only with card-error set.
// - Parameters-valid flag is set once valid recording parameters are loaded.
// - Read-only items only report status; writable items accept writes.
package logger_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] err_code_off = 8'h08;
  localparam logic [7:0] count_off = 8'h0c;
  localparam logic [7:0] store_code_off = 8'h10;
  localparam logic [7:0] limit_off = 8'h14;
  localparam logic [7:0] irq_stat_off = 8'h18;
  localparam logic [7:0] irq_mask_off = 8'h1c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int run_bit = 0;
  localparam int trig_bit = 1;
  localparam int cycle_bit = 2;
  localparam int present_bit = 0;
  localparam int busy_bit = 1;
  localparam int error_bit = 2;
  localparam int limit_bit = 3;
  localparam int params_bit = 4;
  localparam int ev_limit_bit = 0;
  localparam int ev_done_bit = 1;
  localparam int ev_error_bit = 2;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [15:0] store_default_code = 16'h5aa5;
  localparam logic [15:0] store_finished_code = 16'h0000;
  localparam logic [15:0] err_invalid_code = 16'h0001;
  localparam logic [15:0] err_no_card = 16'h0002;
  localparam logic [15:0] err_card_removed = 16'h0003;
  localparam logic [15:0] code_reset = 16'h0000;
  localparam logic [31:0] limit_reset = 32'h0000_0000;
  localparam logic [2:0] irq_reset = 3'h0;

  typedef struct packed {
    logic done;
    logic fail;
    logic [15:0] code;
  } card_resp_t;

  typedef enum logic {store_idle, store_busy} store_state_t;

endpackage : logger_pkg

// ===== design/sample_logger_control.sv
module sample_logger_control (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sample_valid,
  input wire logic card_detect,
  input wire logger_pkg::card_resp_t card_resp,
  output logic card_store_req,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // Card detect filter
  // ****************************************
  logic det_s1_r, det_s2_r, det_s3_r, present_r, present_nxt;

  always_comb begin
    present_nxt = present_r;
    if (det_s2_r == det_s3_r) begin
      present_nxt = det_s3_r;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      det_s1_r <= 1'b0;
      det_s2_r <= 1'b0;
      det_s3_r <= 1'b0;
      present_r <= 1'b0;
    end else begin
      det_s1_r <= card_detect;
      det_s2_r <= det_s1_r;
      det_s3_r <= det_s2_r;
      present_r <= present_nxt;
    end
  end

  // ****************************************
  // Avalon slave handshake
  // ****************************************
  // Every access takes exactly one wait cycle so read data can come from a flop.
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_fire;

  assign waitrequest = (read | write) & ~ack_r;
  assign wr_fire = write & ack_r;
  assign readdata = rdata_r;

  // ****************************************
  // Logger state
  // ****************************************
  logic run_r, run_nxt, trig_r, trig_nxt, cycle_r, cycle_nxt;
  logic trig_prev_r, limit_prev_r;
  logic params_r, params_nxt;
  logic [15:0] code_r, code_nxt, err_code_r, err_code_nxt;
  logic [31:0] limit_r, limit_nxt, count_r, count_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, events;
  logic err_r, err_nxt;
  logger_pkg::store_state_t state_r, state_nxt;
  logic limit_flag, capture, trig_rise, lim_rise, code_ok;

  // In cycle recording the store space wraps, so capture never stops there.
  assign limit_flag = cycle_r | ((limit_r != 32'h0) && (count_r >= limit_r));
  assign capture = run_r & sample_valid & params_r & (cycle_r | ~limit_flag);
  assign trig_rise = trig_r & ~trig_prev_r;
  assign lim_rise = limit_flag & ~limit_prev_r;
  assign code_ok = (code_r == logger_pkg::store_default_code);
  assign card_store_req = (state_r == logger_pkg::store_busy);
  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    run_nxt = run_r;
    trig_nxt = trig_r;
    cycle_nxt = cycle_r;
    params_nxt = params_r;
    code_nxt = code_r;
    limit_nxt = limit_r;
    count_nxt = count_r;
    irq_mask_nxt = irq_mask_r;
    state_nxt = state_r;
    err_nxt = err_r;
    err_code_nxt = err_code_r;
    events = 3'h0;
    ack_nxt = (read | write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (capture) begin
      count_nxt = count_r + 32'h1;
    end
    if (lim_rise) begin
      events[logger_pkg::ev_limit_bit] = 1'b1;
    end
    // Writes to status, error code and count fall through untouched.
    if (wr_fire) begin
      unique case (address)
        logger_pkg::ctrl_off: begin
          m = merge({29'h0, cycle_r, trig_r, run_r}, writedata, byteenable);
          run_nxt = m[logger_pkg::run_bit];
          trig_nxt = m[logger_pkg::trig_bit];
          cycle_nxt = m[logger_pkg::cycle_bit];
        end
        logger_pkg::store_code_off: begin
          m = merge({16'h0, code_r}, writedata, byteenable);
          code_nxt = m[15:0];
        end
        logger_pkg::limit_off: begin
          m = merge(limit_r, writedata, byteenable);
          limit_nxt = m;
          params_nxt = (m != 32'h0);
        end
        logger_pkg::irq_mask_off: begin
          m = merge({29'h0, irq_mask_r}, writedata, byteenable);
          irq_mask_nxt = m[2:0];
        end
        default: begin
          m = 32'h0;
        end
      endcase
    end
    unique case (state_r)
      logger_pkg::store_idle: begin
        if (trig_rise | lim_rise) begin
          if (code_ok && present_r) begin
            state_nxt = logger_pkg::store_busy;
          end else if (!code_ok && trig_rise) begin
            err_nxt = 1'b1;
            err_code_nxt = logger_pkg::err_invalid_code;
            events[logger_pkg::ev_error_bit] = 1'b1;
          end else if (code_ok) begin
            err_nxt = 1'b1;
            err_code_nxt = logger_pkg::err_no_card;
            events[logger_pkg::ev_error_bit] = 1'b1;
          end
        end
      end
      logger_pkg::store_busy: begin
        if (!present_r) begin
          state_nxt = logger_pkg::store_idle;
          err_nxt = 1'b1;
          err_code_nxt = logger_pkg::err_card_removed;
          events[logger_pkg::ev_error_bit] = 1'b1;
        end else if (card_resp.fail) begin
          state_nxt = logger_pkg::store_idle;
          err_nxt = 1'b1;
          err_code_nxt = card_resp.code;
          events[logger_pkg::ev_error_bit] = 1'b1;
        end else if (card_resp.done) begin
          state_nxt = logger_pkg::store_idle;
          err_nxt = 1'b0;
          // Hardware finish wins over a software write in the same cycle.
          code_nxt = logger_pkg::store_finished_code;
          events[logger_pkg::ev_done_bit] = 1'b1;
        end
      end
    endcase
    irq_stat_nxt = irq_stat_r | events;
    if (wr_fire && address == logger_pkg::irq_stat_off && byteenable[0]) begin
      irq_stat_nxt = (irq_stat_r & ~writedata[2:0]) | events;
    end
    if ((read | write) && !ack_r) begin
      unique case (address)
        logger_pkg::ctrl_off: rdata_nxt = {29'h0, cycle_r, trig_r, run_r};
        logger_pkg::status_off: rdata_nxt = {27'h0, params_r, limit_flag, err_r,
                                             card_store_req, present_r};
        logger_pkg::err_code_off: rdata_nxt = {16'h0, err_r ? err_code_r : 16'h0};
        logger_pkg::count_off: rdata_nxt = count_r;
        logger_pkg::store_code_off: rdata_nxt = {16'h0, code_r};
        logger_pkg::limit_off: rdata_nxt = limit_r;
        logger_pkg::irq_stat_off: rdata_nxt = {29'h0, irq_stat_r};
        logger_pkg::irq_mask_off: rdata_nxt = {29'h0, irq_mask_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      run_r <= 1'b0;
      trig_r <= 1'b0;
      cycle_r <= 1'b0;
      trig_prev_r <= 1'b0;
      limit_prev_r <= 1'b0;
      params_r <= 1'b0;
      code_r <= logger_pkg::code_reset;
      limit_r <= logger_pkg::limit_reset;
      count_r <= 32'h0;
      irq_stat_r <= logger_pkg::irq_reset;
      irq_mask_r <= logger_pkg::irq_reset;
      state_r <= logger_pkg::store_idle;
      err_r <= 1'b0;
      err_code_r <= logger_pkg::code_reset;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      run_r <= run_nxt;
      trig_r <= trig_nxt;
      cycle_r <= cycle_nxt;
      trig_prev_r <= trig_r;
      limit_prev_r <= limit_flag;
      params_r <= params_nxt;
      code_r <= code_nxt;
      limit_r <= limit_nxt;
      count_r <= count_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      state_r <= state_nxt;
      err_r <= err_nxt;
      err_code_r <= err_code_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  run_kept_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(run_r) |-> $past(wr_fire && address == logger_pkg::ctrl_off))
    else $error("run flag cleared without a software write");

  stopped_a: assert property (@(posedge clock) disable iff (!nrst)
    !run_r && sample_valid |=> $stable(count_r))
    else $error("record counted while not running");

  count_step_a: assert property (@(posedge clock) disable iff (!nrst)
    capture |=> count_r == $past(count_r) + 32'h1)
    else $error("record count did not step by one");

  limit_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    !cycle_r && (limit_r != 32'h0) && (count_r >= limit_r) |-> limit_flag && !capture)
    else $error("limit reached but flag low or still capturing");

  trig_start_a: assert property (@(posedge clock) disable iff (!nrst)
    state_r == logger_pkg::store_idle && trig_rise && code_ok && present_r
    |=> card_store_req ##1 card_store_req || $past(card_resp.done || card_resp.fail))
    else $error("store trigger did not start a transfer");

  bad_code_a: assert property (@(posedge clock) disable iff (!nrst)
    state_r == logger_pkg::store_idle && trig_rise && !code_ok
    |=> !card_store_req && err_r && err_code_r == logger_pkg::err_invalid_code)
    else $error("invalid store code was not refused");

  done_code_a: assert property (@(posedge clock) disable iff (!nrst)
    card_store_req && present_r && !card_resp.fail && card_resp.done
    |=> !card_store_req && code_r == logger_pkg::store_finished_code)
    else $error("finished store did not clear code and busy");

  auto_start_a: assert property (@(posedge clock) disable iff (!nrst)
    state_r == logger_pkg::store_idle && lim_rise && code_ok && present_r |=> card_store_req)
    else $error("limit reached but saving did not start");

  fail_code_a: assert property (@(posedge clock) disable iff (!nrst)
    card_store_req && present_r && card_resp.fail
    |=> err_r && err_code_r == $past(card_resp.code) && !card_store_req)
    else $error("card failure not recorded");

  present_a: assert property (@(posedge clock) disable iff (!nrst)
    $changed(present_r) |-> $past(det_s2_r == det_s3_r) && present_r == $past(det_s3_r))
    else $error("card present changed without agreement");

  params_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::limit_off && byteenable == 4'hf && writedata != 32'h0
    |=> params_r)
    else $error("parameters valid not set after load");

  ro_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::count_off && !capture |=> $stable(count_r))
    else $error("write to record count changed it");

  busy_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    card_store_req |=> card_store_req || $past(card_resp.done || card_resp.fail || !present_r))
    else $error("storing busy dropped without an ending event");

  no_start_a: assert property (@(posedge clock) disable iff (!nrst)
    !card_store_req && !trig_rise && !lim_rise |=> !card_store_req)
    else $error("store started without a trigger or limit edge");

  no_card_a: assert property (@(posedge clock) disable iff (!nrst)
    state_r == logger_pkg::store_idle && (trig_rise || lim_rise) && code_ok && !present_r
    |=> err_r && err_code_r == logger_pkg::err_no_card && !card_store_req)
    else $error("start without a card was not refused");

  card_removed_a: assert property (@(posedge clock) disable iff (!nrst)
    card_store_req && !present_r
    |=> err_r && err_code_r == logger_pkg::err_card_removed && !card_store_req)
    else $error("card removal during a store not reported");

  err_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    card_store_req && present_r && !card_resp.fail && card_resp.done |=> !err_r)
    else $error("card error flag kept after a clean store");

  params_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::limit_off && byteenable == 4'hf && writedata == 32'h0
    |=> !params_r)
    else $error("parameters valid kept after a zero limit");

  code_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::store_code_off && byteenable[1:0] == 2'h3
    && !card_store_req
    |=> code_r == $past(writedata[15:0]))
    else $error("store code write did not land");

  run_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::ctrl_off && byteenable[0]
    |=> run_r == $past(writedata[logger_pkg::run_bit]))
    else $error("recording run flag write did not land");

  irq_set_a: assert property (@(posedge clock) disable iff (!nrst)
    (|events) |=> (irq_stat_r & $past(events)) == $past(events))
    else $error("event lost against a status clear");

  ro_status_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_fire && address == logger_pkg::status_off |=> $stable(params_r) && $stable(limit_r))
    else $error("write to status changed logger state");

  err_hidden_a: assert property (@(posedge clock) disable iff (!nrst)
    (read || write) && !ack_r && address == logger_pkg::err_code_off && !err_r
    |=> readdata == 32'h0)
    else $error("error code shown while no error is set");

  count_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !capture |=> $stable(count_r))
    else $error("record count moved without a capture");

endmodule : sample_logger_control

// ===== verif/card_model.sv
module card_model (
  input wire logic clock,
  input wire logic card_store_req,
  input wire logic present,
  input wire logic fail_cmd,
  input wire logic [15:0] fail_code,
  output logic card_detect,
  output logger_pkg::card_resp_t card_resp
);
  timeunit 1ns;
  timeprecision 1ns;
  int busy_cycles;
  // ****************************************
  // Card behaviour
  // ****************************************
  assign card_detect = present;
  initial begin
    card_resp = '0;
    busy_cycles = 0;
  end
  // The code lines toggle every cycle so that a code taken outside a failure pulse is caught.
  always @(posedge clock) begin
    card_resp.done <= 1'b0;
    card_resp.fail <= 1'b0;
    card_resp.code <= ~card_resp.code;
    if (card_store_req && busy_cycles == 6) begin
      card_resp.done <= ~fail_cmd;
      card_resp.fail <= fail_cmd;
      card_resp.code <= fail_code;
      busy_cycles <= 0;
    end else if (card_store_req) begin
      busy_cycles <= busy_cycles + 1;
    end else begin
      busy_cycles <= 0;
    end
  end
endmodule : card_model

// ===== verif/tb_sample_logger_control.sv
module tb_sample_logger_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, read, write, sample_valid, present, fail_cmd;
  logic waitrequest, card_detect, card_store_req, irq;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [15:0] fail_code;
  logger_pkg::card_resp_t card_resp;
  int errors, comparisons, seed, lim, exp_count;
  logic cyc;
  sample_logger_control DUT (.clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sample_valid(sample_valid), .card_detect(card_detect),
    .card_resp(card_resp), .card_store_req(card_store_req), .irq(irq));
  card_model card (.clock(clock), .card_store_req(card_store_req), .present(present),
    .fail_cmd(fail_cmd), .fail_code(fail_code), .card_detect(card_detect),
    .card_resp(card_resp));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waitrequest is sampled on the rising edge, the same edge where a write lands and read data
  // stands; the request is only released after that edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      complete_run();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd_chk
  // Reference count: captures only while running, and stops at the limit unless cycle recording.
  task automatic samples(input int k, input bit run);
    repeat (k) begin
      @(posedge clock);
      sample_valid <= 1'b1;
      @(posedge clock);
      sample_valid <= 1'b0;
      if (run && (cyc || exp_count < lim)) begin
        exp_count++;
      end
    end
  endtask : samples
  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (card_store_req !== v && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask : wait_req
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, read, write, sample_valid, fail_cmd, address, writedata} = '0;
    byteenable = 4'hf;
    present = 1'b1;
    seed = 85745;
    lim = 3 + ($random(seed) & 3);
    fail_code = 16'h8000 | 16'($random(seed));
    exp_count = 0;
    cyc = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(logger_pkg::status_off, 32'h0000_0001);
    rd_chk(8'h20, 32'h0000_0000);
    bus(1'b1, logger_pkg::count_off, 32'hffff_ffff);
    rd_chk(logger_pkg::count_off, 32'h0000_0000);
    bus(1'b1, logger_pkg::status_off, 32'h0000_00ff);
    rd_chk(logger_pkg::status_off, 32'h0000_0001);
    bus(1'b1, logger_pkg::limit_off, 32'(lim));
    rd_chk(logger_pkg::status_off, 32'h0000_0011);
    samples(2, 1'b0);
    rd_chk(logger_pkg::count_off, 32'(exp_count));
    bus(1'b1, logger_pkg::store_code_off, 32'h0000_5aa5);
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0001);
    samples(lim - 1, 1'b1);
    rd_chk(logger_pkg::count_off, 32'(exp_count));
    samples(3, 1'b1);
    wait_req(1'b1);
    rd_chk(logger_pkg::status_off, 32'h0000_001b);
    wait_req(1'b0);
    rd_chk(logger_pkg::count_off, 32'(exp_count));
    rd_chk(logger_pkg::ctrl_off, 32'h0000_0001);
    rd_chk(logger_pkg::status_off, 32'h0000_0019);
    rd_chk(logger_pkg::store_code_off, 32'h0000_0000);
    rd_chk(logger_pkg::irq_stat_off, 32'h0000_0003);
    // The mask and status load at the write edge, so irq is looked at half a cycle later.
    bus(1'b1, logger_pkg::irq_mask_off, 32'h0000_0002);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, logger_pkg::irq_stat_off, 32'h0000_0002);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, logger_pkg::irq_mask_off, 32'h0000_0001);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, logger_pkg::irq_stat_off, 32'h0000_0007);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    // Interrupts stay masked while the card is written.
    bus(1'b1, logger_pkg::irq_mask_off, 32'h0000_0000);
    fail_cmd <= 1'b1;
    bus(1'b1, logger_pkg::store_code_off, 32'h0000_5aa5);
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0003);
    wait_req(1'b1);
    wait_req(1'b0);
    rd_chk(logger_pkg::status_off, 32'h0000_001d);
    rd_chk(logger_pkg::err_code_off, {16'h0, fail_code});
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0001);
    bus(1'b1, logger_pkg::store_code_off, 32'h0000_1234);
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0003);
    repeat (4) @(negedge clock);
    chk({31'h0, card_store_req}, 32'h0000_0000);
    rd_chk(logger_pkg::err_code_off, 32'h0000_0001);
    present <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(logger_pkg::status_off, 32'h0000_001c);
    // A valid start with no card inserted is refused with its own code.
    bus(1'b1, logger_pkg::store_code_off, 32'h0000_5aa5);
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0001);
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0003);
    rd_chk(logger_pkg::err_code_off, {16'h0, logger_pkg::err_no_card});
    // Cycle recording keeps capturing past the limit.
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0005);
    cyc = 1'b1;
    samples(2, 1'b1);
    rd_chk(logger_pkg::count_off, 32'(exp_count));
    bus(1'b1, logger_pkg::ctrl_off, 32'h0000_0000);
    samples(2, 1'b0);
    rd_chk(logger_pkg::count_off, 32'(exp_count));
    complete_run();
  end
endmodule : tb_sample_logger_control
